// >>> design/iosr_defs.svh
`ifndef IOSR_DEFS_SVH
`define IOSR_DEFS_SVH

// i/o space addresses (io_addr); data-space address adds the offset
`define IOSR_IO_BIT_TOP 6'h1F
`define IOSR_DS_OFFSET 9'h020
`define IOSR_IO_TOP_DS 9'h05F
`define IOSR_EXT_LOW_DS 9'h060
// i/o map positions chosen for this block
`define IOSR_IO_SCR0 6'h00
`define IOSR_IO_INA 6'h01
`define IOSR_IO_DIRA 6'h02
`define IOSR_IO_OUTA 6'h03
`define IOSR_IO_INC 6'h04
`define IOSR_IO_DIRC 6'h05
`define IOSR_IO_OUTC 6'h06
`define IOSR_IO_SCR1 6'h0A
`define IOSR_IO_SCR2 6'h0B
`define IOSR_IO_FLAG 6'h0C
// storage slot indices
`define IOSR_SLOT_SCR0 3'h0
`define IOSR_SLOT_SCR1 3'h1
`define IOSR_SLOT_SCR2 3'h2
`define IOSR_SLOT_OUTA 3'h3
`define IOSR_SLOT_DIRA 3'h4
`define IOSR_SLOT_OUTC 3'h5
`define IOSR_SLOT_DIRC 3'h6
`define IOSR_SLOT_COUNT 7
`define IOSR_RESET_BYTE 8'h00
`define IOSR_SENSE_BYTE 8'h00

`endif

// >>> design/iosr_pkg.sv
`default_nettype none
package iosr_pkg;
  typedef enum logic [2:0] {
    IOSR_OP_NONE,
    IOSR_OP_IO_RD,
    IOSR_OP_IO_WR,
    IOSR_OP_MEM_RD,
    IOSR_OP_MEM_WR,
    IOSR_OP_BIT_SET,
    IOSR_OP_BIT_CLR,
    IOSR_OP_BIT_TEST
  } iosr_op_t;

  typedef struct packed {
    iosr_op_t op;
    logic [8:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iosr_req_t;

  typedef struct packed {
    logic hit;
    logic bit_val;
    logic [7:0] rdata;
  } iosr_rsp_t;
endpackage
`default_nettype wire

// >>> design/iosr_store.sv
`include "iosr_defs.svh"
`default_nettype none
// byte storage, one registered read port
module iosr_store #(
  parameter int SLOTS = `IOSR_SLOT_COUNT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_slot_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [2:0] rd_slot_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_reg [SLOTS];

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          mem_reg[g] <= `IOSR_RESET_BYTE;
        end else if (wr_en_in && wr_slot_in == 3'(g)) begin
          mem_reg[g] <= wr_data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= `IOSR_RESET_BYTE;
    end else if (int'(rd_slot_in) < SLOTS) begin
      rd_data_out <= (wr_en_in && wr_slot_in == rd_slot_in) ? wr_data_in : mem_reg[rd_slot_in];
    end else begin
      rd_data_out <= `IOSR_RESET_BYTE;
    end
  end
endmodule // iosr_store
`default_nettype wire

// >>> design/iosr_top.sv
// Summary of operation
// - every i/o location is reachable by memory read and write operations through data space.
// - locations 0x00-0x1F accept bit set, bit clear and bit test operations.
// - i/o read and write operations reach only i/o addresses 0x00-0x3F.
// - a low-range i/o register appears in data space at its i/o address plus 0x20.
// - the extended region 0x60-0x1FF holds nothing; memory read and write operations there get no hit.
// - certain status flags clear when a one is written to their bit; zero leaves them.
// - bit set and clear change only the targeted bit, leaving other flags intact.
// - three 8-bit scratch registers store any value written.
// - spare port a and c output and direction registers are plain 8-bit storage.
// - spare input sense locations are reserved and are not storage.
`include "iosr_defs.svh"
`default_nettype none
module iosr_top (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire iosr_pkg::iosr_req_t REQ_IN,
  input wire logic [7:0] FLAG_EVENT_IN,
  output iosr_pkg::iosr_rsp_t RSP_OUT,
  output logic [7:0] FLAG_OUT
);
  logic is_io_op, is_mem_op, is_bit_op;
  logic [5:0] io_addr;
  logic addr_ok;
  logic [2:0] slot;
  logic slot_ok, flag_sel, sense_sel;
  logic [7:0] cur_byte, new_byte;
  logic store_wr;
  logic [7:0] store_rd;
  logic [7:0] flag_reg, flag_clr;
  logic rd_is_store_reg, rd_is_flag_reg, hit_reg, bit_reg, want_bit_reg;
  logic [7:0] fixed_rd_reg;
  logic [2:0] bit_sel_reg;
  logic [7:0] shadow [`IOSR_SLOT_COUNT];

  assign is_io_op = REQ_IN.op == iosr_pkg::IOSR_OP_IO_RD
    || REQ_IN.op == iosr_pkg::IOSR_OP_IO_WR;
  assign is_mem_op = REQ_IN.op == iosr_pkg::IOSR_OP_MEM_RD
    || REQ_IN.op == iosr_pkg::IOSR_OP_MEM_WR;
  assign is_bit_op = REQ_IN.op == iosr_pkg::IOSR_OP_BIT_SET
    || REQ_IN.op == iosr_pkg::IOSR_OP_BIT_CLR
    || REQ_IN.op == iosr_pkg::IOSR_OP_BIT_TEST;

  // address decode into i/o space
  always_comb begin
    io_addr = 6'h00;
    addr_ok = 1'b0;
    if (is_io_op) begin
      io_addr = REQ_IN.addr[5:0];
      addr_ok = REQ_IN.addr[8:6] == 3'h0;
    end else if (is_mem_op) begin
      // extended region lies above the i/o window; nothing held there
      if (REQ_IN.addr >= `IOSR_DS_OFFSET && REQ_IN.addr <= `IOSR_IO_TOP_DS) begin
        io_addr = 6'(REQ_IN.addr - `IOSR_DS_OFFSET);
        addr_ok = 1'b1;
      end
    end else if (is_bit_op) begin
      io_addr = REQ_IN.addr[5:0];
      addr_ok = REQ_IN.addr[8:5] == 4'h0;
    end
  end

  always_comb begin
    slot = `IOSR_SLOT_SCR0;
    slot_ok = 1'b0;
    flag_sel = 1'b0;
    sense_sel = 1'b0;
    if (addr_ok) begin
      unique case (io_addr)
        `IOSR_IO_SCR0: begin slot = `IOSR_SLOT_SCR0; slot_ok = 1'b1; end
        `IOSR_IO_SCR1: begin slot = `IOSR_SLOT_SCR1; slot_ok = 1'b1; end
        `IOSR_IO_SCR2: begin slot = `IOSR_SLOT_SCR2; slot_ok = 1'b1; end
        `IOSR_IO_OUTA: begin slot = `IOSR_SLOT_OUTA; slot_ok = 1'b1; end
        `IOSR_IO_DIRA: begin slot = `IOSR_SLOT_DIRA; slot_ok = 1'b1; end
        `IOSR_IO_OUTC: begin slot = `IOSR_SLOT_OUTC; slot_ok = 1'b1; end
        `IOSR_IO_DIRC: begin slot = `IOSR_SLOT_DIRC; slot_ok = 1'b1; end
        `IOSR_IO_FLAG: flag_sel = 1'b1;
        `IOSR_IO_INA, `IOSR_IO_INC: sense_sel = 1'b1;
        default: ;
      endcase
    end
  end

  // read-modify-write for bit ops keeps the other bits
  assign cur_byte = store_rd_now(slot);
  function automatic logic [7:0] store_rd_now(input logic [2:0] s);
    store_rd_now = shadow[s];
  endfunction
  genvar g;
  generate
    for (g = 0; g < `IOSR_SLOT_COUNT; g++) begin : g_shadow
      always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          shadow[g] <= `IOSR_RESET_BYTE;
        end else if (store_wr && slot == 3'(g)) begin
          shadow[g] <= new_byte;
        end
      end
    end
  endgenerate

  always_comb begin
    new_byte = REQ_IN.wdata;
    if (REQ_IN.op == iosr_pkg::IOSR_OP_BIT_SET) begin
      new_byte = cur_byte | (8'h01 << REQ_IN.bit_sel);
    end else if (REQ_IN.op == iosr_pkg::IOSR_OP_BIT_CLR) begin
      new_byte = cur_byte & ~(8'h01 << REQ_IN.bit_sel);
    end
  end

  assign store_wr = slot_ok && (REQ_IN.op == iosr_pkg::IOSR_OP_IO_WR
    || REQ_IN.op == iosr_pkg::IOSR_OP_MEM_WR
    || REQ_IN.op == iosr_pkg::IOSR_OP_BIT_SET
    || REQ_IN.op == iosr_pkg::IOSR_OP_BIT_CLR);

  iosr_store #(
    .SLOTS(`IOSR_SLOT_COUNT)
  ) u_store (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .wr_en_in(store_wr),
    .wr_slot_in(slot),
    .wr_data_in(new_byte),
    .rd_slot_in(slot),
    .rd_data_out(store_rd)
  );

  // write-one-to-clear flags; a bit op touches only its bit
  always_comb begin
    flag_clr = 8'h00;
    if (flag_sel) begin
      unique case (REQ_IN.op)
        iosr_pkg::IOSR_OP_IO_WR, iosr_pkg::IOSR_OP_MEM_WR: flag_clr = REQ_IN.wdata;
        iosr_pkg::IOSR_OP_BIT_SET: flag_clr = 8'h01 << REQ_IN.bit_sel;
        default: flag_clr = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flag_reg <= `IOSR_RESET_BYTE;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | FLAG_EVENT_IN;
    end
  end
  assign FLAG_OUT = flag_reg;

  // answer registered one cycle after the request
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_is_store_reg <= 1'b0;
      rd_is_flag_reg <= 1'b0;
      hit_reg <= 1'b0;
      want_bit_reg <= 1'b0;
      bit_sel_reg <= 3'h0;
      fixed_rd_reg <= `IOSR_RESET_BYTE;
    end else begin
      rd_is_store_reg <= slot_ok;
      rd_is_flag_reg <= flag_sel;
      hit_reg <= slot_ok || flag_sel || sense_sel;
      want_bit_reg <= REQ_IN.op == iosr_pkg::IOSR_OP_BIT_TEST;
      bit_sel_reg <= REQ_IN.bit_sel;
      fixed_rd_reg <= flag_sel ? flag_reg : `IOSR_SENSE_BYTE;
    end
  end

  always_comb begin
    RSP_OUT.hit = hit_reg;
    RSP_OUT.rdata = rd_is_store_reg ? store_rd : fixed_rd_reg;
    RSP_OUT.bit_val = (rd_is_store_reg ? store_rd[bit_sel_reg] : fixed_rd_reg[bit_sel_reg])
      & want_bit_reg;
  end

  AST_WRITE_READBACK: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    ((REQ_IN.op == iosr_pkg::IOSR_OP_MEM_WR || REQ_IN.op == iosr_pkg::IOSR_OP_IO_WR)
      && slot_ok) ##1 (REQ_IN.op == iosr_pkg::IOSR_OP_NONE) ##1
    ((REQ_IN.op == iosr_pkg::IOSR_OP_MEM_RD || REQ_IN.op == iosr_pkg::IOSR_OP_IO_RD)
      && slot_ok && slot == $past(slot, 2))
    |=> RSP_OUT.rdata == $past(REQ_IN.wdata, 3))
    else $error("stored byte not read back");
  AST_IO_STORE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (REQ_IN.op == iosr_pkg::IOSR_OP_IO_WR && slot_ok)
    |=> shadow[$past(slot)] == $past(REQ_IN.wdata))
    else $error("io write not stored");
  AST_REFUSED_NOWRITE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    !addr_ok |-> !store_wr && flag_clr == 8'h00)
    else $error("refused access wrote state");
  AST_REFUSED_ZERO: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (REQ_IN.op != iosr_pkg::IOSR_OP_NONE && !addr_ok)
    |=> RSP_OUT.rdata == `IOSR_SENSE_BYTE && !RSP_OUT.bit_val)
    else $error("refused access returned data");
  AST_FLAG_SET_WINS: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    1'b1 |=> (FLAG_OUT & $past(FLAG_EVENT_IN)) == $past(FLAG_EVENT_IN))
    else $error("flag event lost");
  AST_EXT_MISS: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (is_mem_op && REQ_IN.addr >= `IOSR_EXT_LOW_DS) |=> !RSP_OUT.hit)
    else $error("extended region answered");
  AST_BIT_RANGE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (is_bit_op && REQ_IN.addr[5]) |=> !RSP_OUT.hit)
    else $error("bit op above low range answered");
  AST_IO_RANGE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (is_io_op && REQ_IN.addr[8:6] != 3'h0) |=> !RSP_OUT.hit)
    else $error("io op beyond 64 locations answered");
  AST_OFFSET: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (REQ_IN.op == iosr_pkg::IOSR_OP_MEM_RD && REQ_IN.addr == `IOSR_DS_OFFSET) |-> slot_ok
      && slot == `IOSR_SLOT_SCR0)
    else $error("data-space offset wrong");
  AST_W1C: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (flag_sel && REQ_IN.op == iosr_pkg::IOSR_OP_MEM_WR && FLAG_EVENT_IN == 8'h00)
    |=> FLAG_OUT == ($past(flag_reg) & ~$past(REQ_IN.wdata)))
    else $error("flag clear wrong");
  AST_BIT_ONLY: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (store_wr && REQ_IN.op == iosr_pkg::IOSR_OP_BIT_SET)
    |=> (shadow[$past(slot)] ^ $past(cur_byte)) == (8'h01 << $past(REQ_IN.bit_sel))
      || shadow[$past(slot)] == $past(cur_byte))
    else $error("bit set touched other bits");
  AST_SENSE_NOSTORE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    sense_sel |-> !store_wr ##1 RSP_OUT.rdata == `IOSR_SENSE_BYTE)
    else $error("sense location acts as storage");
  AST_STORE_ALL: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (REQ_IN.op == iosr_pkg::IOSR_OP_MEM_WR && slot_ok) |=> shadow[$past(slot)] == $past(REQ_IN.wdata))
    else $error("memory write not stored");

  COV_BIT_TEST: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    REQ_IN.op == iosr_pkg::IOSR_OP_BIT_TEST && slot_ok ##1 RSP_OUT.bit_val);
  COV_IO_WR: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    REQ_IN.op == iosr_pkg::IOSR_OP_IO_WR && slot_ok);
  COV_FLAG_CLR: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    flag_sel && flag_clr != 8'h00);
  COV_EXT_MISS: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    is_mem_op && REQ_IN.addr >= `IOSR_EXT_LOW_DS);
endmodule // iosr_top
`default_nettype wire

// >>> tb/iosr_core_model.sv
`default_nettype none
module iosr_core_model (
  input wire logic clk_in,
  input wire iosr_pkg::iosr_rsp_t rsp_in,
  output var iosr_pkg::iosr_req_t req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_out = '0;
  // one instruction a call, held up to the taking edge
  task automatic issue(input iosr_pkg::iosr_op_t op, input logic [8:0] addr,
                       input logic [2:0] bit_sel, input logic [7:0] wdata,
                       output iosr_pkg::iosr_rsp_t rsp);
    @(posedge clk_in);
    #1;
    req_out = '{op, addr, bit_sel, wdata};
    @(posedge clk_in);
    #1;
    req_out.op = iosr_pkg::IOSR_OP_NONE;
    // released data line does not keep its last value
    req_out.wdata = ~wdata;
    rsp = rsp_in;
  endtask
endmodule // iosr_core_model
`default_nettype wire

// >>> tb/io_space_scratch_registers_tb.sv
`include "iosr_defs.svh"
`default_nettype none
module io_space_scratch_registers_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] flag_event = 8'h00;
  iosr_pkg::iosr_req_t req;
  iosr_pkg::iosr_rsp_t rsp;
  iosr_pkg::iosr_rsp_t r;
  logic [7:0] flag_out;
  logic [7:0] store [7];
  logic [7:0] exp_flag = 8'h00;
  logic [5:0] map [7] = '{`IOSR_IO_SCR0, `IOSR_IO_SCR1, `IOSR_IO_SCR2, `IOSR_IO_OUTA,
                          `IOSR_IO_DIRA, `IOSR_IO_OUTC, `IOSR_IO_DIRC};
  int seed = 32'hf7f791ef;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  always #20 sys_clk = ~sys_clk;
  iosr_top i_dut (.SYS_CLK_IN(sys_clk), .RST_IN(rst), .REQ_IN(req),
                  .FLAG_EVENT_IN(flag_event), .RSP_OUT(rsp), .FLAG_OUT(flag_out));
  iosr_core_model i_core (.clk_in(sys_clk), .rsp_in(rsp), .req_out(req));
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] ds(input int k, input logic mem);
    ds = {3'h0, map[k]} + (mem ? `IOSR_DS_OFFSET : 9'h000);
  endfunction
  function automatic logic [7:0] bit_upd(input logic [7:0] v, input logic [2:0] b,
                                         input logic s);
    bit_upd = v;
    bit_upd[b] = s;
  endfunction
  task automatic rd(input iosr_pkg::iosr_op_t op, input logic [8:0] a, input logic hit,
                    input logic [7:0] v);
    iosr_pkg::iosr_rsp_t q;
    i_core.issue(op, a, 3'h0, 8'h00, q);
    chk_bit(q.hit, hit);
    chk_byte(q.rdata, v);
  endtask
  task automatic rd_all(input logic mem);
    for (int i = 0; i < 7; i++) begin
      rd(mem ? iosr_pkg::IOSR_OP_MEM_RD : iosr_pkg::IOSR_OP_IO_RD, ds(i, mem), 1'b1, store[i]);
    end
  endtask
  initial begin
    logic [7:0] d;
    logic [2:0] b;
    logic m;
    int k;
    store = '{default: `IOSR_RESET_BYTE};
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd_all(1'b0);
    for (int n = 0; n < 40; n++) begin
      k = $unsigned($random(seed)) % 7;
      d = $random(seed);
      m = n[0];
      store[k] = d;
      i_core.issue(m ? iosr_pkg::IOSR_OP_MEM_WR : iosr_pkg::IOSR_OP_IO_WR, ds(k, m),
                   3'h0, d, r);
      rd(m ? iosr_pkg::IOSR_OP_IO_RD : iosr_pkg::IOSR_OP_MEM_RD, ds(k, !m), 1'b1, d);
    end
    rd_all(1'b1);
    for (int n = 0; n < 24; n++) begin
      k = $unsigned($random(seed)) % 7;
      b = $random(seed);
      d = $random(seed);
      i_core.issue(d[0] ? iosr_pkg::IOSR_OP_BIT_SET : iosr_pkg::IOSR_OP_BIT_CLR,
                   ds(k, 1'b0), b, d, r);
      store[k] = bit_upd(store[k], b, d[0]);
      i_core.issue(iosr_pkg::IOSR_OP_BIT_TEST, ds(k, 1'b0), b ^ d[3:1], 8'h00, r);
      chk_bit(r.bit_val, store[k][b ^ d[3:1]]);
      chk_byte(r.rdata, store[k]);
    end
    rd(iosr_pkg::IOSR_OP_IO_RD, 9'(`IOSR_IO_INA), 1'b1, `IOSR_SENSE_BYTE);
    rd(iosr_pkg::IOSR_OP_MEM_RD, 9'(`IOSR_IO_INC) + `IOSR_DS_OFFSET, 1'b1,
       `IOSR_SENSE_BYTE);
    rd(iosr_pkg::IOSR_OP_IO_RD, 9'h040, 1'b0, 8'h00);
    rd(iosr_pkg::IOSR_OP_BIT_TEST, 9'h020, 1'b0, 8'h00);
    rd(iosr_pkg::IOSR_OP_MEM_RD, `IOSR_EXT_LOW_DS + 9'($unsigned($random(seed)) % 416),
       1'b0, 8'h00);
    rd(iosr_pkg::IOSR_OP_IO_RD, ds(0, 1'b0) + `IOSR_DS_OFFSET + 9'h020, 1'b0, 8'h00);
    for (int n = 0; n < 8; n++) begin
      d = $random(seed);
      @(posedge sys_clk);
      #1;
      flag_event = d;
      @(posedge sys_clk);
      #1;
      flag_event = 8'h00;
      exp_flag = exp_flag | d;
      chk_byte(flag_out, exp_flag);
      d = $random(seed);
      i_core.issue(n[0] ? iosr_pkg::IOSR_OP_MEM_WR : iosr_pkg::IOSR_OP_IO_WR,
                   9'(`IOSR_IO_FLAG) + (n[0] ? `IOSR_DS_OFFSET : 9'h000), 3'h0, d, r);
      exp_flag = exp_flag & ~d;
      chk_byte(flag_out, exp_flag);
      b = $random(seed);
      i_core.issue(iosr_pkg::IOSR_OP_BIT_SET, 9'(`IOSR_IO_FLAG), b, 8'h00, r);
      exp_flag[b] = 1'b0;
      chk_byte(flag_out, exp_flag);
      i_core.issue(iosr_pkg::IOSR_OP_BIT_CLR, 9'(`IOSR_IO_FLAG), ~b, 8'h00, r);
      rd(iosr_pkg::IOSR_OP_MEM_RD, 9'(`IOSR_IO_FLAG) + `IOSR_DS_OFFSET, 1'b1,
         exp_flag);
    end
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    store = '{default: `IOSR_RESET_BYTE};
    chk_byte(flag_out, 8'h00);
    rd_all(1'b1);
    tally_and_finish();
  end
endmodule // io_space_scratch_registers_tb
`default_nettype wire
